// ===== core/dxr_consts.svh
// Constants for the display extension register bank
// Function
// - CPU memory reads load four plane latches
// - Group bit picks standard or extra clocks
// - Three-bit code selects one clock source
// - Cursor mode: replace or XOR pixels
// - Blink disable makes cursor steady
// - Unused cursor attribute bits read zero
// - Switch strobe captures data bits 15-8
// - Switch strobe: write-only decode, data bits 7-0 ignored
// - Extensions reachable only after unlock 0EAh
// - Colour emulation ports pulse event strobe only in CGA mode
// - Mono emulation ports pulse event strobe only in CGA mode
// - CRTC index port strobes when events enabled
// - Emulation off stops port strobes, CRTC group events still fire
// - Bitmap enable forces 0B0000h 64K decode
// - Range 2 protect blocks CRTC 00-08
// - Ranges 1, 0 protect 09-0B and 0C
// - Event ranges strobe on CRTC group writes
// - Pointer AND mask then XOR pattern
`ifndef DXR_CONSTS_SVH
`define DXR_CONSTS_SVH
`define DXR_IX_LATCH0   8'ha0
`define DXR_IX_LATCH1   8'ha1
`define DXR_IX_LATCH2   8'ha2
`define DXR_IX_LATCH3   8'ha3
`define DXR_IX_CLKGRP   8'ha4
`define DXR_IX_CURATTR  8'ha5
`define DXR_IX_SWITCH_CAPTURE_STROBE    8'hea
`define DXR_IX_EMUL     8'heb
`define DXR_IX_SWREAD   8'hf7
`define DXR_IX_UNLOCK   8'h06
`define DXR_UNLOCK_KEY  8'hea
`define DXR_PORT_SEQIX  16'h03c4
`define DXR_PORT_SEQDAT 16'h03c5
`define DXR_PORT_CMODE  16'h03d8
`define DXR_PORT_CPAL   16'h03d9
`define DXR_PORT_CEXT   16'h03de
`define DXR_PORT_MMODE  16'h03b8
`define DXR_PORT_MCFG   16'h03bf
`define DXR_PORT_CCRTC  16'h03d4
`define DXR_PORT_MCRTC  16'h03b4
`define DXR_PORT_CDATA  16'h03d5
`define DXR_PORT_MDATA  16'h03b5
`define DXR_CUR_MASK    8'h89
`define DXR_CLKGRP_MASK 8'h10
`define DXR_CLKGRP_BIT  4
`define DXR_PTR_EN_BIT  7
`define DXR_CMODE_BIT   3
`define DXR_BLINK_BIT   0
`define DXR_RST_BYTE    8'h00
`define DXR_CRTC_A_LAST 8'h08
`define DXR_CRTC_B_LAST 8'h0b
`define DXR_CRTC_C      8'h0c
`define DXR_MAP_MONO    2'b11
`define DXR_PTR_LAST    5'h1f
`endif

// ===== core/dxr_pkg.sv
// Types for the display extension register bank
`default_nettype none
package dxr_pkg;
   // Host I/O cycle
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [15:0] addr;
      logic [15:0] wdata;
   } dxr_io_t;
   // Emulation control fields
   typedef struct packed {
      logic       emul_en;
      logic       bitmap_en;
      logic [2:0] wprot;
      logic [2:0] evt_en;
   } dxr_emul_t;
   typedef enum logic [1:0] {
      DXR_ST_IDLE  = 2'b00,
      DXR_ST_PULSE = 2'b01
   } dxr_evt_st_t;
endpackage : dxr_pkg
`default_nettype wire

// ===== core/dxr_latch_mem.sv
// Four plane read latches, one byte each
`default_nettype none
`include "dxr_consts.svh"
module dxr_latch_mem (
   input  wire logic        ref_clk,
   input  wire logic        sys_rst,
   input  wire logic        clk_en,
   input  wire logic        mem_load,
   input  wire logic [31:0] mem_data,
   input  wire logic        reg_wr,
   input  wire logic [1:0]  reg_sel,
   input  wire logic [7:0]  reg_wdata,
   output logic      [7:0]  rd_data_ff,
   output logic      [31:0] all_ff
);
   logic [7:0] lat_ff [4];

   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_plane
         always_ff @(posedge ref_clk) begin
            if (sys_rst) begin
               lat_ff[g] <= `DXR_RST_BYTE;
            end else if (clk_en) begin
               if (mem_load) begin
                  lat_ff[g] <= mem_data[8*g +: 8];
               end else if (reg_wr && (reg_sel == 2'(g))) begin
                  lat_ff[g] <= reg_wdata;
               end
            end
         end
         assign all_ff[8*g +: 8] = lat_ff[g];
      end
   endgenerate

   // Registered read port
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         rd_data_ff <= `DXR_RST_BYTE;
      end else if (clk_en) begin
         rd_data_ff <= lat_ff[reg_sel];
      end
   end
endmodule : dxr_latch_mem
`default_nettype wire

// ===== core/dxr_regs.sv
// Display extension register bank on the sequencer index/data port
`default_nettype none
`include "dxr_consts.svh"
module dxr_regs (
   input  wire logic           ref_clk,
   input  wire logic           sys_rst,
   input  wire logic           clk_en,
   input  wire dxr_pkg::dxr_io_t io,
   input  wire logic           mem_rd,
   input  wire logic [31:0]    mem_rdata,
   input  wire logic [1:0]     misc_clk_sel,
   input  wire logic           misc_cga_mode,
   input  wire logic           vret_protect,
   input  wire logic [1:0]     gfx_map_sel,
   input  wire logic [7:0]     crtc_index,
   input  wire logic [7:0]     video_in,
   input  wire logic           ptr_area,
   input  wire logic           ptr_and_bit,
   input  wire logic           ptr_xor_bit,
   input  wire logic           cur_on,
   input  wire logic           blink_phase,
   input  wire logic           cur_pix,
   output logic [7:0]          io_rdata_ff,
   output logic [2:0]          clk_src_ff,
   output logic                cur_xor_ff,
   output logic                cur_show_ff,
   output logic [7:0]          video_out_ff,
   output logic                crtc_wr_ok_ff,
   output logic [1:0]          mem_map_ff,
   output logic                evt_strobe_n_ff,
   output logic [31:0]         latches_ff
);
   logic [7:0]        seq_ix_ff;
   logic              unlocked_ff;
   logic              clkgrp_ff;
   logic [7:0]        cur_ff;
   logic [7:0]        sw_ff;
   dxr_pkg::dxr_emul_t emul_ff;
   dxr_pkg::dxr_evt_st_t evt_st_ff;
   logic [7:0]        lat_rd;
   logic              dat_wr;
   logic              dat_rd;
   logic              ext_wr;
   logic [2:0]        grp;
   logic              trig;
   logic [7:0]        nxt_rd;
   logic [7:0]        vmask;
   logic [7:0]        cur_pix8;

   // One-hot CRTC group: a=00-08, b=09-0B, c=0C
   function automatic logic [2:0] crtc_grp(input logic [7:0] ix);
      crtc_grp[2] = (ix <= `DXR_CRTC_A_LAST);
      crtc_grp[1] = (ix > `DXR_CRTC_A_LAST) && (ix <= `DXR_CRTC_B_LAST);
      crtc_grp[0] = (ix == `DXR_CRTC_C);
   endfunction : crtc_grp

   assign dat_wr = io.wr && (io.addr == `DXR_PORT_SEQDAT);
   assign dat_rd = io.rd && (io.addr == `DXR_PORT_SEQDAT);
   assign ext_wr = dat_wr && unlocked_ff;
   assign grp    = crtc_grp(crtc_index);

   ////////////////////////////////////////////////////////////
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         seq_ix_ff <= `DXR_RST_BYTE;
      end else if (clk_en && io.wr && io.addr == `DXR_PORT_SEQIX) begin
         seq_ix_ff <= io.wdata[7:0];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         unlocked_ff <= 1'b0;
      end else if (clk_en && dat_wr && seq_ix_ff == `DXR_IX_UNLOCK) begin
         unlocked_ff <= (io.wdata[7:0] == `DXR_UNLOCK_KEY);
      end
   end

   dxr_latch_mem u_lat (
      .ref_clk   (ref_clk),
      .sys_rst   (sys_rst),
      .clk_en    (clk_en),
      .mem_load  (mem_rd),
      .mem_data  (mem_rdata),
      .reg_wr    (ext_wr && seq_ix_ff[7:2] == 6'(`DXR_IX_LATCH0 >> 2)),
      .reg_sel   (seq_ix_ff[1:0]),
      .reg_wdata (io.wdata[7:0]),
      .rd_data_ff(lat_rd),
      .all_ff    (latches_ff)
   );

   ////////////////////////////////////////////////////////////
   // clock group bit, left to software
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         clkgrp_ff <= 1'b0;
      end else if (clk_en && ext_wr && seq_ix_ff == `DXR_IX_CLKGRP) begin
         clkgrp_ff <= io.wdata[`DXR_CLKGRP_BIT];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         clk_src_ff <= 3'h0;
      end else if (clk_en) begin
         clk_src_ff <= {clkgrp_ff, misc_clk_sel};
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         cur_ff <= `DXR_RST_BYTE;
      end else if (clk_en && ext_wr && seq_ix_ff == `DXR_IX_CURATTR) begin
         cur_ff <= io.wdata[7:0] & `DXR_CUR_MASK;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         sw_ff <= `DXR_RST_BYTE;
      end else if (clk_en && ext_wr && seq_ix_ff == `DXR_IX_SWITCH_CAPTURE_STROBE) begin
         sw_ff <= io.wdata[15:8];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         emul_ff <= '0;
      end else if (clk_en && ext_wr && seq_ix_ff == `DXR_IX_EMUL) begin
         emul_ff <= io.wdata[7:0];
      end
   end

   ////////////////////////////////////////////////////////////
   // Locked bank reads as zero; strobe index has no readback
   always_comb begin
      nxt_rd = `DXR_RST_BYTE;
      if (seq_ix_ff == `DXR_IX_UNLOCK) begin
         nxt_rd = {7'h00, unlocked_ff};
      end else if (unlocked_ff) begin
         case (seq_ix_ff)
            `DXR_IX_LATCH0, `DXR_IX_LATCH1,
            `DXR_IX_LATCH2, `DXR_IX_LATCH3: nxt_rd = lat_rd;
            `DXR_IX_CLKGRP:  nxt_rd = {3'h0, clkgrp_ff, 4'h0};
            `DXR_IX_CURATTR: nxt_rd = cur_ff;
            `DXR_IX_EMUL:    nxt_rd = emul_ff;
            `DXR_IX_SWREAD:  nxt_rd = sw_ff;
            default:         nxt_rd = `DXR_RST_BYTE;
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         io_rdata_ff <= `DXR_RST_BYTE;
      end else if (clk_en && dat_rd) begin
         io_rdata_ff <= nxt_rd;
      end
   end

   ////////////////////////////////////////////////////////////
   // cursor replace or XOR
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         cur_xor_ff <= 1'b0;
      end else if (clk_en) begin
         cur_xor_ff <= cur_ff[`DXR_CMODE_BIT];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         cur_show_ff <= 1'b0;
      end else if (clk_en) begin
         cur_show_ff <= cur_on && (cur_ff[`DXR_BLINK_BIT] || blink_phase);
      end
   end

   // Cursor merge then pointer, pointer sits last in the path
   always_comb begin
      cur_pix8 = {8{cur_pix}};
      vmask    = video_in;
      if (cur_on && (cur_ff[`DXR_BLINK_BIT] || blink_phase)) begin
         vmask = cur_ff[`DXR_CMODE_BIT] ? (video_in ^ cur_pix8)
                                        : (cur_pix ? cur_pix8 : video_in);
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         video_out_ff <= `DXR_RST_BYTE;
      end else if (clk_en) begin
         if (cur_ff[`DXR_PTR_EN_BIT] && ptr_area) begin
            video_out_ff <= (vmask & {8{ptr_and_bit}}) ^ {8{ptr_xor_bit}};
         end else begin
            video_out_ff <= vmask;
         end
      end
   end

   ////////////////////////////////////////////////////////////
   // bitmap forces mono 64K map
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         mem_map_ff <= 2'h0;
      end else if (clk_en) begin
         mem_map_ff <= emul_ff.bitmap_en ? `DXR_MAP_MONO : gfx_map_sel;
      end
   end

   // range 2 or retrace bit blocks
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         crtc_wr_ok_ff <= 1'b1;
      end else if (clk_en) begin
         crtc_wr_ok_ff <= !(grp[2] && (emul_ff.wprot[2] || vret_protect))
                       && !(grp[1] && emul_ff.wprot[1])
                       && !(grp[0] && emul_ff.wprot[0]);
      end
   end

   ////////////////////////////////////////////////////////////
   always_comb begin
      trig = 1'b0;
      if (io.wr && emul_ff.emul_en) begin
         if (misc_cga_mode && (io.addr == `DXR_PORT_CMODE ||
             io.addr == `DXR_PORT_CPAL || io.addr == `DXR_PORT_CEXT)) begin
            trig = 1'b1;
         end
         if (misc_cga_mode && (io.addr == `DXR_PORT_MMODE ||
             io.addr == `DXR_PORT_MCFG)) begin
            trig = 1'b1;
         end
         if (|emul_ff.evt_en && (io.addr == `DXR_PORT_CCRTC ||
             io.addr == `DXR_PORT_MCRTC)) begin
            trig = 1'b1;
         end
      end
      // CRTC group events, not gated by emulation enable
      if (io.wr && |(grp & emul_ff.evt_en) && (io.addr == `DXR_PORT_CDATA ||
          io.addr == `DXR_PORT_MDATA)) begin
         trig = 1'b1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         evt_st_ff       <= dxr_pkg::DXR_ST_IDLE;
         evt_strobe_n_ff <= 1'b1;
      end else if (clk_en) begin
         case (evt_st_ff)
            dxr_pkg::DXR_ST_IDLE: begin
               evt_strobe_n_ff <= !trig;
               if (trig) begin
                  evt_st_ff <= dxr_pkg::DXR_ST_PULSE;
               end
            end
            dxr_pkg::DXR_ST_PULSE: begin
               evt_strobe_n_ff <= !trig;
               if (!trig) begin
                  evt_st_ff <= dxr_pkg::DXR_ST_IDLE;
               end
            end
            default: begin
               evt_st_ff       <= dxr_pkg::DXR_ST_IDLE;
               evt_strobe_n_ff <= 1'b1;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////
   a_strobe_cause: assert property (@(posedge ref_clk) disable iff (sys_rst)
      clk_en && $past(clk_en) && !evt_strobe_n_ff |-> $past(trig))
      else $error("strobe without cause");
   a_strobe_fires: assert property (@(posedge ref_clk) disable iff (sys_rst)
      clk_en && trig |=> !evt_strobe_n_ff)
      else $error("strobe missed");
   a_emul_off: assert property (@(posedge ref_clk) disable iff (sys_rst)
      clk_en && !emul_ff.emul_en && io.wr && io.addr == `DXR_PORT_CMODE
      |=> evt_strobe_n_ff)
      else $error("strobe with emulation off");
   a_cur_zero: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (cur_ff & ~`DXR_CUR_MASK) == 8'h00)
      else $error("unused cursor bit set");
   a_lock_gate: assert property (@(posedge ref_clk) disable iff (sys_rst)
      clk_en && !unlocked_ff && dat_wr && seq_ix_ff == `DXR_IX_EMUL
      |=> $stable(emul_ff))
      else $error("locked write took effect");
   a_clk_code: assert property (@(posedge ref_clk) disable iff (sys_rst)
      clk_en |=> clk_src_ff == {$past(clkgrp_ff), $past(misc_clk_sel)})
      else $error("clock code wrong");
   a_sw_capture: assert property (@(posedge ref_clk) disable iff (sys_rst)
      clk_en && ext_wr && seq_ix_ff == `DXR_IX_SWITCH_CAPTURE_STROBE
      |=> sw_ff == $past(io.wdata[15:8]))
      else $error("switch capture wrong");
   a_map_force: assert property (@(posedge ref_clk) disable iff (sys_rst)
      clk_en && emul_ff.bitmap_en |=> mem_map_ff == `DXR_MAP_MONO)
      else $error("mono map not forced");
   a_wprot_grp: assert property (@(posedge ref_clk) disable iff (sys_rst)
      clk_en && grp[0] && emul_ff.wprot[0] |=> !crtc_wr_ok_ff)
      else $error("register 0C not protected");
   a_ptr_off: assert property (@(posedge ref_clk) disable iff (sys_rst)
      clk_en && !cur_ff[`DXR_PTR_EN_BIT] |=> video_out_ff == $past(vmask))
      else $error("pointer drawn while disabled");
   c_strobe: cover property (@(posedge ref_clk) !evt_strobe_n_ff);
   c_unlock: cover property (@(posedge ref_clk) $rose(unlocked_ff));
   c_ptr: cover property (@(posedge ref_clk) cur_ff[`DXR_PTR_EN_BIT] && ptr_area);
endmodule : dxr_regs
`default_nettype wire

// ===== verification/dxr_host_model.sv
// Host CPU model issuing I/O cycles on the sequencer index/data port
`default_nettype none
module dxr_host_model (
   input  wire logic             ref_clk,
   input  wire logic [7:0]       io_rdata_ff,
   output var  dxr_pkg::dxr_io_t io
);
   timeunit 1ns;
   timeprecision 1ps;
   initial io = '0;
   ////////////////////////////////////////////////////////////////////////////////
   // One-cycle pulse; released data is inverted so a stale byte never matches
   task automatic cycle(input logic w, input logic [15:0] a, input logic [15:0] d);
      @(posedge ref_clk);
      io.wr    <= w;
      io.rd    <= ~w;
      io.addr  <= a;
      io.wdata <= d;
      @(posedge ref_clk);
      io.wr    <= 1'b0;
      io.rd    <= 1'b0;
      io.wdata <= ~d;
   endtask : cycle
   task automatic ext_wr(input logic [7:0] ix, input logic [7:0] v, input logic [7:0] sw);
      cycle(1'b1, 16'h03c4, {8'h00, ix});
      cycle(1'b1, 16'h03c5, {sw, v});
   endtask : ext_wr
   // Read data lands at the taken edge and is sampled one cycle later
   task automatic ext_rd(input logic [7:0] ix, output logic [7:0] v);
      cycle(1'b1, 16'h03c4, {8'h00, ix});
      cycle(1'b0, 16'h03c5, 16'h0000);
      @(posedge ref_clk);
      #1 v = io_rdata_ff;
   endtask : ext_rd
endmodule : dxr_host_model
`default_nettype wire

// ===== verification/dxr_regs_test.sv
// Self-checking bench for the display extension register bank
`default_nettype none
module dxr_regs_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic             ref_clk = 1'b0;
   logic             sys_rst = 1'b1;
   logic             mem_rd = 1'b0;
   logic             misc_cga_mode = 1'b0;
   logic             ptr_area = 1'b0;
   logic             ptr_and_bit = 1'b1;
   logic             ptr_xor_bit = 1'b0;
   logic             vret_protect = 1'b0;
   logic             cur_on = 1'b0;
   logic             blink_phase = 1'b0;
   logic             cur_pix = 1'b0;
   logic [31:0]      mem_rdata = 32'h0;
   logic [1:0]       misc_clk_sel = 2'h0;
   logic [1:0]       gfx_map_sel = 2'h0;
   logic [7:0]       crtc_index = 8'h0;
   logic [7:0]       video_in = 8'h0;
   logic [7:0]       io_rdata_ff, video_out_ff;
   logic [2:0]       clk_src_ff;
   logic [1:0]       mem_map_ff;
   logic [31:0]      latches_ff;
   logic             cur_xor_ff, cur_show_ff, crtc_wr_ok_ff, evt_strobe_n_ff;
   dxr_pkg::dxr_io_t io;
   int               bad_count = 0;
   int               checks_done = 0;
   int               n;
   logic [7:0]       v;
   logic [15:0]      pt [5] = '{16'h03d8, 16'h03d9, 16'h03de, 16'h03b8, 16'h03bf};
   dxr_host_model host_u (.ref_clk(ref_clk), .io_rdata_ff(io_rdata_ff), .io(io));
   dxr_regs dut_u (
      .ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(1'b1), .io(io), .mem_rd(mem_rd),
      .mem_rdata(mem_rdata), .misc_clk_sel(misc_clk_sel), .misc_cga_mode(misc_cga_mode),
      .vret_protect(vret_protect), .gfx_map_sel(gfx_map_sel), .crtc_index(crtc_index),
      .video_in(video_in), .ptr_area(ptr_area), .ptr_and_bit(ptr_and_bit),
      .ptr_xor_bit(ptr_xor_bit), .cur_on(cur_on), .blink_phase(blink_phase),
      .cur_pix(cur_pix),
      .io_rdata_ff(io_rdata_ff), .clk_src_ff(clk_src_ff), .cur_xor_ff(cur_xor_ff),
      .cur_show_ff(cur_show_ff), .video_out_ff(video_out_ff), .crtc_wr_ok_ff(crtc_wr_ok_ff),
      .mem_map_ff(mem_map_ff), .evt_strobe_n_ff(evt_strobe_n_ff), .latches_ff(latches_ff)
   );
   always #25 ref_clk = ~ref_clk;
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         bad_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk_val
   task automatic chk_cnt(input int got, input int exp);
      checks_done++;
      if (got != exp) begin
         bad_count++;
         $display("Error at %0t: strobes %h expected %h", $time, got, exp);
      end
   endtask : chk_cnt
   task automatic rd_chk(input logic [7:0] ix, input logic [7:0] exp);
      host_u.ext_rd(ix, v);
      chk_val({24'h0, v}, {24'h0, exp});
   endtask : rd_chk
   // Counts low strobe cycles over a window that covers either latency
   task automatic wr_cnt(input logic [15:0] a, input int exp);
      host_u.cycle(1'b1, a, 16'h00a5);
      n = 0;
      repeat (3) begin
         #1 if (evt_strobe_n_ff === 1'b0) n++;
         @(posedge ref_clk);
      end
      chk_cnt(n, exp);
   endtask : wr_cnt
   task automatic settle;
      repeat (3) @(posedge ref_clk);
      #1;
   endtask : settle
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_lock;
      host_u.ext_wr(8'heb, 8'hff, 8'h00);
      rd_chk(8'heb, 8'h00);
      host_u.ext_wr(8'h06, 8'hea, 8'h00);
      rd_chk(8'heb, 8'h00);
      rd_chk(8'ha5, 8'h00);
      rd_chk(8'ha4, 8'h00);
      $display("lock test done");
   endtask : t_lock
   task automatic t_cursor;
      host_u.ext_wr(8'ha5, 8'hff, 8'h00);
      rd_chk(8'ha5, 8'h89);
      host_u.ext_wr(8'ha5, 8'h08, 8'h00);
      settle();
      chk_val(cur_xor_ff, 1'b1);
      host_u.ext_wr(8'ha5, 8'h01, 8'h00);
      rd_chk(8'ha5, 8'h01);
      @(posedge ref_clk);
      cur_on <= 1'b1;
      ptr_area <= 1'b1;
      ptr_and_bit <= 1'b0;
      ptr_xor_bit <= 1'b1;
      video_in <= 8'h5a;
      settle();
      chk_val(video_out_ff, 8'h5a);
      chk_val(cur_show_ff, 1'b1);
      host_u.ext_wr(8'ha5, 8'h80, 8'h00);
      settle();
      chk_val(video_out_ff, 8'hff);
      chk_val(cur_show_ff, 1'b0);
      @(posedge ref_clk);
      ptr_and_bit <= 1'b1;
      settle();
      chk_val(video_out_ff, 8'ha5);
      @(posedge ref_clk);
      blink_phase <= 1'b1;
      cur_pix <= 1'b1;
      settle();
      chk_val(cur_show_ff, 1'b1);
      chk_val(video_out_ff, 8'h00);
      @(posedge ref_clk);
      ptr_area <= 1'b0;
      $display("cursor test done");
   endtask : t_cursor
   task automatic t_clock;
      // group changed while no display traffic runs
      for (int g = 0; g < 2; g++) begin
         host_u.ext_wr(8'ha4, g[0] ? 8'h10 : 8'h00, 8'h00);
         for (int m = 0; m < 4; m++) begin
            @(posedge ref_clk);
            misc_clk_sel <= m[1:0];
            settle();
            chk_val(clk_src_ff, {g[0], m[1:0]});
         end
      end
      $display("clock test done");
   endtask : t_clock
   task automatic t_latch;
      @(posedge ref_clk);
      mem_rd <= 1'b1;
      mem_rdata <= 32'h44332211;
      @(posedge ref_clk);
      mem_rd <= 1'b0;
      mem_rdata <= 32'hbbccddee;
      for (int i = 0; i < 4; i++) begin
         rd_chk(8'ha0 + 8'(i), 8'h11 * 8'(i + 1));
      end
      host_u.ext_wr(8'ha2, 8'hc3, 8'h00);
      rd_chk(8'ha2, 8'hc3);
      chk_val(latches_ff, 32'h44c32211);
      $display("latch test done");
   endtask : t_latch
   task automatic t_switch;
      host_u.ext_wr(8'hea, 8'h3c, 8'h96);
      rd_chk(8'hf7, 8'h96);
      rd_chk(8'hea, 8'h00);
      $display("switch test done");
   endtask : t_switch
   task automatic t_emul;
      @(posedge ref_clk);
      misc_cga_mode <= 1'b1;
      host_u.ext_wr(8'heb, 8'h80, 8'h00);
      for (int i = 0; i < 5; i++) begin
         wr_cnt(pt[i], 1);
      end
      wr_cnt(16'h03d4, 0);
      host_u.ext_wr(8'heb, 8'h81, 8'h00);
      wr_cnt(16'h03d4, 1);
      wr_cnt(16'h03b4, 1);
      host_u.ext_wr(8'heb, 8'h00, 8'h00);
      wr_cnt(16'h03d8, 0);
      misc_cga_mode <= 1'b0;
      host_u.ext_wr(8'heb, 8'h80, 8'h00);
      wr_cnt(16'h03d8, 0);
      $display("emulation test done");
   endtask : t_emul
   task automatic t_crtc;
      @(posedge ref_clk);
      gfx_map_sel <= 2'h1;
      host_u.ext_wr(8'heb, 8'h40, 8'h00);
      settle();
      chk_val(mem_map_ff, 2'h3);
      host_u.ext_wr(8'heb, 8'h20, 8'h00);
      settle();
      chk_val(mem_map_ff, 2'h1);
      @(posedge ref_clk);
      crtc_index <= 8'h03;
      settle();
      chk_val(crtc_wr_ok_ff, 1'b0);
      @(posedge ref_clk);
      crtc_index <= 8'h0a;
      settle();
      chk_val(crtc_wr_ok_ff, 1'b1);
      host_u.ext_wr(8'heb, 8'h10, 8'h00);
      settle();
      chk_val(crtc_wr_ok_ff, 1'b0);
      host_u.ext_wr(8'heb, 8'h0c, 8'h00);
      crtc_index <= 8'h0c;
      settle();
      chk_val(crtc_wr_ok_ff, 1'b0);
      wr_cnt(16'h03d5, 0);
      crtc_index <= 8'h03;
      wr_cnt(16'h03d5, 1);
      host_u.ext_wr(8'heb, 8'h00, 8'h00);
      settle();
      chk_val(crtc_wr_ok_ff, 1'b1);
      @(posedge ref_clk);
      vret_protect <= 1'b1;
      settle();
      chk_val(crtc_wr_ok_ff, 1'b0);
      $display("crtc test done");
   endtask : t_crtc
   ////////////////////////////////////////////////////////////////////////////////
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : end_of_test
   initial begin
      repeat (8) @(posedge ref_clk);
      sys_rst <= 1'b0;
      t_lock();
      t_cursor();
      t_clock();
      t_latch();
      t_switch();
      t_emul();
      t_crtc();
      end_of_test();
   end
   // Whole run needs well under a thousand cycles
   initial begin
      repeat (20000) @(posedge ref_clk);
      bad_count++;
      end_of_test();
   end
endmodule : dxr_regs_test
`default_nettype wire
